// [logic/bfi_pkg.sv]
// Package for the branch and flag instruction unit.
// Assumes a 16-bit core that hands decoded opcodes and operands in.
package bfi_pkg;
    // ------------------------------------------------------------
    // Opcodes handled by this unit
    // ------------------------------------------------------------
    localparam logic [7:0] OP_BRANCH_CARRY_SET    = 8'hB0;
    localparam logic [7:0] OP_BRANCH_IF_EQUAL     = 8'hF0;
    localparam logic [7:0] OP_BRANCH_IF_MINUS     = 8'h30;
    localparam logic [7:0] OP_BRANCH_NOT_EQUAL    = 8'hD0;
    localparam logic [7:0] OP_BRANCH_IF_PLUS      = 8'h10;
    localparam logic [7:0] OP_BRANCH_ALWAYS       = 8'h80;
    localparam logic [7:0] OP_SOFTWARE_INTERRUPT  = 8'h00;
    localparam logic [7:0] OP_BRANCH_OVF_CLEAR    = 8'h50;
    localparam logic [7:0] OP_BRANCH_OVF_SET      = 8'h70;
    localparam logic [7:0] OP_MEMORY_BIT_CLEAR    = 8'h14;
    localparam logic [7:0] OP_CARRY_CLEAR         = 8'h18;
    localparam logic [7:0] OP_IRQ_DISABLE_CLEAR   = 8'h58;
    localparam logic [7:0] OP_WIDTH_FLAG_CLEAR    = 8'hD8;
    localparam logic [7:0] OP_STATUS_BITS_CLEAR   = 8'hC2;
    localparam logic [7:0] OP_OVERFLOW_CLEAR      = 8'hB8;
    localparam logic [7:0] OP_CMP_IMMEDIATE       = 8'hC9;
    localparam logic [7:0] OP_CMP_DIRECT          = 8'hC5;
    // ------------------------------------------------------------
    // Processor status bit positions
    // ------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_I = 2;
    localparam int FLAG_M = 5;
    localparam int FLAG_V = 6;
    localparam int FLAG_N = 7;
    // Reset values and soft interrupt vector
    localparam logic [15:0] STATUS_RESET  = 16'h0004;
    localparam logic [15:0] SP_RESET      = 16'h0FFF;
    localparam logic [15:0] TRAP_VECTOR   = 16'hFFFA;
    localparam logic [15:0] PC_RESET      = 16'h0000;
    localparam logic [7:0]  BANK_RESET    = 8'h00;
    // Lengths
    localparam logic [15:0] LEN_ONE   = 16'h0001;
    localparam logic [15:0] LEN_TWO   = 16'h0002;
    localparam logic [15:0] LEN_THREE = 16'h0003;
endpackage

// [logic/bfi_cmp.sv]
// Width-aware compare of accumulator against operand.
// Assumes the caller presents the width flag with the operands.
`timescale 1ns/1ps
module bfi_cmp
    import bfi_pkg::*;
(
    // Operands
    input  wire logic [15:0] i_acc,
    input  wire logic [15:0] i_mem,
    input  wire logic        i_byte_mode,
    // Flag results
    output logic             o_n,
    output logic             o_z,
    output logic             o_c
);
    logic [16:0] diff;
    // ------------------------------------------------------------
    // Subtract, difference stays inside this module; only the flags go out
    // ------------------------------------------------------------
    always_comb begin
        diff = 17'h0_0000;
        o_n  = 1'b0;
        o_z  = 1'b0;
        o_c  = 1'b0;
        if (i_byte_mode) begin
            diff = {9'h000, i_acc[7:0]} - {9'h000, i_mem[7:0]};
            o_n  = diff[7];
            o_z  = (diff[7:0] == 8'h00);
            o_c  = ~diff[8];
        end else begin
            diff = {1'b0, i_acc} - {1'b0, i_mem};
            o_n  = diff[15];
            o_z  = (diff[15:0] == 16'h0000);
            o_c  = ~diff[16];
        end
    end
endmodule // bfi_cmp

// [logic/bfi_unit.sv]
// Execution of branch, flag clear, bit clear, compare and soft interrupt.
// Assumes one instruction presented per i_valid pulse, operands already fetched.
`timescale 1ns/1ps
// How it works
// - Carry-set branch taken when C is one
// - Equal on Z one, not-equal on zero
// - Minus on N one, plus on zero
// - Overflow-clear on V zero, set on one
// - Always-branch adjusts bank on carry or borrow
// - Soft interrupt pushes bank, PC, status; vectors
// - Bit clear zeroes masked memory bits only
// - Carry clear zeroes C, one byte
// - Interrupt-disable clear zeroes I
// - Width flag clear selects sixteen bits
// - Overflow clear zeroes V only
// - Status clear zeroes mask-selected bits
// - Compare subtracts, sets flags, stores nothing
// - Width flag picks sixteen or eight bits
module bfi_unit
    import bfi_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // Instruction
    input  wire logic        i_valid,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [7:0]  i_operand,
    input  wire logic [15:0] i_imm16,
    input  wire logic [15:0] i_acc,
    input  wire logic [15:0] i_mem_rdata,
    // Memory write port
    output logic             o_mem_we,
    output logic [15:0]      o_mem_addr,
    output logic [7:0]       o_mem_wdata,
    output logic             o_busy,
    // Architectural state
    output logic [15:0]      o_pc,
    output logic [7:0]       o_bank,
    output logic [15:0]      o_status,
    output logic [15:0]      o_sp
);
    typedef enum logic [2:0] {ST_IDLE, ST_PCH, ST_PCL, ST_PSH, ST_PSL} bfi_state_type;

    bfi_state_type state_reg, state_next;
    logic [15:0] pc_reg, pc_next, status_reg, status_next, sp_reg, sp_next;
    logic        busy_reg, busy_next;
    logic [7:0]  bank_reg, bank_next, wdata_reg, wdata_next;
    logic [15:0] addr_reg, addr_next;
    logic        we_reg, we_next;
    logic        cmp_n, cmp_z, cmp_c;
    logic [15:0] pc_after, ofs16;
    logic [16:0] tgt;
    logic        take;

    // ------------------------------------------------------------
    // Compare datapath
    // ------------------------------------------------------------
    bfi_cmp u_cmp (
        .i_acc       (i_acc),
        .i_mem       ((i_opcode == OP_CMP_IMMEDIATE) ? i_imm16 : i_mem_rdata),
        .i_byte_mode (status_reg[FLAG_M]),
        .o_n         (cmp_n),
        .o_z         (cmp_z),
        .o_c         (cmp_c)
    );

    // Branch target from sign-extended offset
    always_comb begin
        pc_after = pc_reg + LEN_TWO;
        ofs16    = {{8{i_operand[7]}}, i_operand};
        tgt      = {1'b0, pc_after} + {1'b0, ofs16};
        take     = 1'b0;
        unique case (i_opcode)
            OP_BRANCH_CARRY_SET: take = status_reg[FLAG_C];
            OP_BRANCH_IF_EQUAL:  take = status_reg[FLAG_Z];
            OP_BRANCH_NOT_EQUAL: take = ~status_reg[FLAG_Z];
            OP_BRANCH_IF_MINUS:  take = status_reg[FLAG_N];
            OP_BRANCH_IF_PLUS:   take = ~status_reg[FLAG_N];
            OP_BRANCH_OVF_CLEAR: take = ~status_reg[FLAG_V];
            OP_BRANCH_OVF_SET:   take = status_reg[FLAG_V];
            default:             take = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state; push sequence runs one byte per cycle
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        pc_next    = pc_reg;
        status_next = status_reg;
        sp_next    = sp_reg;
        bank_next  = bank_reg;
        we_next    = 1'b0;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (i_valid) begin
                    unique case (i_opcode)
                        OP_BRANCH_CARRY_SET, OP_BRANCH_IF_EQUAL, OP_BRANCH_NOT_EQUAL,
                        OP_BRANCH_IF_MINUS, OP_BRANCH_IF_PLUS,
                        OP_BRANCH_OVF_CLEAR, OP_BRANCH_OVF_SET: begin
                            pc_next = take ? tgt[15:0] : pc_after;
                        end
                        OP_BRANCH_ALWAYS: begin
                            pc_next = tgt[15:0];
                            if (!i_operand[7] && tgt[16])
                                bank_next = bank_reg + 8'h01;
                            else if (i_operand[7] && !tgt[16])
                                bank_next = bank_reg - 8'h01;
                        end
                        OP_SOFTWARE_INTERRUPT: begin
                            pc_next    = pc_after;
                            we_next    = 1'b1;
                            addr_next  = sp_reg;
                            wdata_next = bank_reg;
                            sp_next    = sp_reg - 16'h0001;
                            state_next = ST_PCH;
                        end
                        OP_MEMORY_BIT_CLEAR: begin
                            we_next    = 1'b1;
                            addr_next  = i_imm16;
                            wdata_next = i_mem_rdata[7:0] & ~i_operand;
                            pc_next    = pc_reg + LEN_THREE;
                        end
                        OP_CARRY_CLEAR: begin
                            status_next[FLAG_C] = 1'b0;
                            pc_next       = pc_reg + LEN_ONE;
                        end
                        OP_IRQ_DISABLE_CLEAR: begin
                            status_next[FLAG_I] = 1'b0;
                            pc_next       = pc_reg + LEN_ONE;
                        end
                        OP_WIDTH_FLAG_CLEAR: begin
                            status_next[FLAG_M] = 1'b0;
                            pc_next       = pc_reg + LEN_ONE;
                        end
                        OP_OVERFLOW_CLEAR: begin
                            status_next[FLAG_V] = 1'b0;
                            pc_next       = pc_reg + LEN_ONE;
                        end
                        OP_STATUS_BITS_CLEAR: begin
                            status_next = status_reg & ~{8'h00, i_operand};
                            pc_next = pc_reg + LEN_TWO;
                        end
                        OP_CMP_IMMEDIATE, OP_CMP_DIRECT: begin
                            status_next[FLAG_N] = cmp_n;
                            status_next[FLAG_Z] = cmp_z;
                            status_next[FLAG_C] = cmp_c;
                            if (i_opcode == OP_CMP_DIRECT)
                                pc_next = pc_reg + LEN_TWO;
                            else
                                pc_next = pc_reg + (status_reg[FLAG_M] ? LEN_TWO : LEN_THREE);
                        end
                        default: pc_next = pc_reg;
                    endcase
                end
            end
            ST_PCH: begin
                we_next = 1'b1; addr_next = sp_reg; wdata_next = pc_reg[15:8];
                sp_next = sp_reg - 16'h0001; state_next = ST_PCL;
            end
            ST_PCL: begin
                we_next = 1'b1; addr_next = sp_reg; wdata_next = pc_reg[7:0];
                sp_next = sp_reg - 16'h0001; state_next = ST_PSH;
            end
            ST_PSH: begin
                we_next = 1'b1; addr_next = sp_reg; wdata_next = status_reg[15:8];
                sp_next = sp_reg - 16'h0001; state_next = ST_PSL;
            end
            ST_PSL: begin
                we_next = 1'b1; addr_next = sp_reg; wdata_next = status_reg[7:0];
                sp_next = sp_reg - 16'h0001;
                status_next[FLAG_I] = 1'b1;
                pc_next   = TRAP_VECTOR;
                bank_next = BANK_RESET;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
        // Busy is registered so the port comes straight from a flip-flop
        busy_next = (state_next != ST_IDLE);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= ST_IDLE;
            pc_reg    <= PC_RESET;
            status_reg <= STATUS_RESET;
            busy_reg  <= 1'b0;
            sp_reg    <= SP_RESET;
            bank_reg  <= BANK_RESET;
            we_reg    <= 1'b0;
            addr_reg  <= 16'h0000;
            wdata_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            pc_reg    <= pc_next;
            status_reg <= status_next;
            busy_reg  <= busy_next;
            sp_reg    <= sp_next;
            bank_reg  <= bank_next;
            we_reg    <= we_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
        end
    end

    // Outputs straight from flip-flops
    assign o_mem_we    = we_reg;
    assign o_mem_addr  = addr_reg;
    assign o_mem_wdata = wdata_reg;
    assign o_busy      = busy_reg;
    assign o_pc        = pc_reg;
    assign o_bank      = bank_reg;
    assign o_status    = status_reg;
    assign o_sp        = sp_reg;
endmodule // bfi_unit

// [sim/bfi_unit_properties.sv]
// Concurrent checks on the branch and flag unit ports.
// Assumes binding onto bfi_unit, one clock, async low reset.
`timescale 1ns/1ps
module bfi_unit_properties
    import bfi_pkg::*;
(
    // Clock, reset and instruction
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_valid,
    input wire logic [7:0]  i_opcode,
    input wire logic [7:0]  i_operand,
    input wire logic [15:0] i_imm16,
    input wire logic [15:0] i_acc,
    input wire logic [15:0] i_mem_rdata,
    // Watched outputs
    input wire logic        o_mem_we,
    input wire logic [15:0] o_mem_addr,
    input wire logic [7:0]  o_mem_wdata,
    input wire logic        o_busy,
    input wire logic [15:0] o_pc,
    input wire logic [7:0]  o_bank,
    input wire logic [15:0] o_status,
    input wire logic [15:0] o_sp
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Offset widening and bank step; the sum uses the base past the branch
    logic [15:0] off16;
    logic [16:0] jump_sum;
    logic [7:0]  bdelta;
    assign off16    = {{8{i_operand[7]}}, i_operand};
    assign jump_sum = {1'b0, o_pc + 16'h0002} + {1'b0, off16};
    assign bdelta   = !i_operand[7] ? {7'h00, jump_sum[16]} : (jump_sum[16] ? 8'h00 : 8'hFF);
    sequence op_s(logic [7:0] op);
        i_valid && !o_busy && i_opcode == op;
    endsequence
    // Five pushes with the vector standing on the last one, then quiet
    sequence push_s;
        o_mem_we [*4] ##1 (o_mem_we && o_pc == TRAP_VECTOR && o_bank == BANK_RESET && o_status[FLAG_I])
            ##1 !o_mem_we;
    endsequence
    property br_p(logic [7:0] op, logic cond);
        op_s(op) |=> o_pc == $past(o_pc) + 16'h0002 + ($past(cond) ? $past(off16) : 16'h0000);
    endproperty
    AST_CARRY_SET_BR: assert property (br_p(OP_BRANCH_CARRY_SET, o_status[FLAG_C]))
        else $error("carry-set branch target wrong");
    AST_EQUAL_BR: assert property (br_p(OP_BRANCH_IF_EQUAL, o_status[FLAG_Z]))
        else $error("equal branch target wrong");
    AST_NOT_EQUAL_BR: assert property (br_p(OP_BRANCH_NOT_EQUAL, !o_status[FLAG_Z]))
        else $error("not-equal branch target wrong");
    AST_MINUS_BR: assert property (br_p(OP_BRANCH_IF_MINUS, o_status[FLAG_N]))
        else $error("minus branch target wrong");
    AST_PLUS_BR: assert property (br_p(OP_BRANCH_IF_PLUS, !o_status[FLAG_N]))
        else $error("plus branch target wrong");
    AST_OVF_CLEAR_BR: assert property (br_p(OP_BRANCH_OVF_CLEAR, !o_status[FLAG_V]))
        else $error("overflow-clear branch target wrong");
    AST_OVF_SET_BR: assert property (br_p(OP_BRANCH_OVF_SET, o_status[FLAG_V]))
        else $error("overflow-set branch target wrong");
    AST_ALWAYS_BANK: assert property (op_s(OP_BRANCH_ALWAYS) |=> o_bank == $past(o_bank) + $past(bdelta))
        else $error("bank not adjusted on branch");
    AST_CARRY_CLR: assert property (op_s(OP_CARRY_CLEAR) |=> o_status == ($past(o_status) & 16'hFFFE)
        && o_pc == $past(o_pc) + 16'h0001) else $error("carry clear wrong");
    AST_OVF_CLR: assert property (op_s(OP_OVERFLOW_CLEAR) |=> o_status == ($past(o_status) & 16'hFFBF))
        else $error("overflow clear wrong");
    AST_STATUS_CLR: assert property (op_s(OP_STATUS_BITS_CLEAR)
        |=> o_status == ($past(o_status) & ~{8'h00, $past(i_operand)})) else $error("status mask clear wrong");
    AST_BIT_CLR: assert property (op_s(OP_MEMORY_BIT_CLEAR) |=> o_mem_we && o_mem_addr == $past(i_imm16)
        && o_mem_wdata == ($past(i_mem_rdata[7:0]) & ~$past(i_operand))) else $error("bit clear write wrong");
    AST_COMPARE: assert property (op_s(OP_CMP_DIRECT) ##0 !o_status[FLAG_M] |=> !o_mem_we
        && o_status[FLAG_C] == ($past(i_acc) >= $past(i_mem_rdata))
        && o_status[FLAG_Z] == ($past(i_acc) == $past(i_mem_rdata)))
        else $error("compare flags wrong");
    AST_SOFT_INT: assert property (op_s(OP_SOFTWARE_INTERRUPT) |=> push_s)
        else $error("soft interrupt sequence wrong");
    AST_BUSY: assert property ($rose(o_busy) |-> o_busy [*4] ##1 !o_busy)
        else $error("busy length wrong");
endmodule // bfi_unit_properties

bind bfi_unit bfi_unit_properties chk_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_valid(i_valid), .i_opcode(i_opcode),
    .i_operand(i_operand), .i_imm16(i_imm16), .i_acc(i_acc), .i_mem_rdata(i_mem_rdata), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_busy(o_busy), .o_pc(o_pc), .o_bank(o_bank),
    .o_status(o_status), .o_sp(o_sp));

// [sim/testbench.sv]
// Directed bench for the branch and flag unit.
// Assumes bfi_unit with its checker bound; expectations come from a small state model.
`timescale 1ns/1ps
module testbench
    import bfi_pkg::*;
;
    logic        i_clk = 0, i_rst_b = 0, i_valid = 0;
    logic [7:0]  i_opcode = 0, i_operand = 0;
    logic [15:0] i_imm16 = 0, i_acc = 0, i_mem_rdata = 0;
    logic        o_mem_we, o_busy;
    logic [7:0]  o_mem_wdata, o_bank, m_bank;
    logic [15:0] o_mem_addr, o_pc, o_status, o_sp, m_pc, m_status, m_sp;
    logic [7:0]  pushes [5];
    int          n_fail = 0, n_tests = 0;
    always #10 i_clk = ~i_clk;
    bfi_unit dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_valid(i_valid), .i_opcode(i_opcode), .i_operand(i_operand),
        .i_imm16(i_imm16), .i_acc(i_acc), .i_mem_rdata(i_mem_rdata), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .o_busy(o_busy), .o_pc(o_pc), .o_bank(o_bank), .o_status(o_status), .o_sp(o_sp));
    task test_done;
        if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // Whole architectural state against the model; every check point is idle
    task chk(input logic we);
        cmp16(o_pc, m_pc, "pc");
        cmp16({8'h00, o_bank}, {8'h00, m_bank}, "bank");
        cmp16(o_status, m_status, "status");
        cmp16(o_sp, m_sp, "stack");
        cmp16({15'h0000, o_mem_we}, {15'h0000, we}, "write strobe");
        cmp16({15'h0000, o_busy}, 16'h0000, "busy");
    endtask
    // One instruction; returns just after the edge that takes it
    task ex(input logic [7:0] op, input logic [7:0] opr, input logic [15:0] imm, input logic [15:0] acc,
            input logic [15:0] mem);
        @(posedge i_clk);
        #1;
        i_valid = 1;
        i_opcode = op;
        i_operand = opr;
        i_imm16 = imm;
        i_acc = acc;
        i_mem_rdata = mem;
        @(posedge i_clk);
        #1;
        i_valid = 0;
    endtask
    task br(input logic [7:0] op, input logic [7:0] off, input logic taken, input logic [7:0] db);
        ex(op, off, 16'h0000, 16'h0000, 16'h0000);
        m_pc = m_pc + 16'h0002 + (taken ? {{8{off[7]}}, off} : 16'h0000);
        m_bank = m_bank + db;
        chk(0);
    endtask
    // Compare; the immediate form carries the operand on i_imm16
    task cmp(input logic [7:0] op, input logic [15:0] a, input logic [15:0] b, input logic [15:0] len);
        logic [15:0] d;
        ex(op, 8'h00, b, a, b);
        d = a - b;
        m_status[FLAG_N] = d[15];
        m_status[FLAG_Z] = (a == b);
        m_status[FLAG_C] = (a >= b);
        m_pc = m_pc + len;
        chk(0);
    endtask
    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        m_pc = PC_RESET;
        m_bank = BANK_RESET;
        m_status = STATUS_RESET;
        m_sp = SP_RESET;
        repeat (6) @(posedge i_clk);
        #1 i_rst_b = 1;
        chk(0);
        ex(OP_IRQ_DISABLE_CLEAR, 8'h00, 16'h0000, 16'h0000, 16'h0000);
        m_status[FLAG_I] = 0;
        m_pc = m_pc + 16'h0001;
        chk(0);
        cmp(OP_CMP_IMMEDIATE, 16'h8005, 16'h8005, 16'h0003);
        br(OP_BRANCH_IF_EQUAL, 8'h10, 1, 8'h00);
        br(OP_BRANCH_NOT_EQUAL, 8'h10, 0, 8'h00);
        br(OP_BRANCH_CARRY_SET, 8'h22, 1, 8'h00);
        br(OP_BRANCH_IF_MINUS, 8'h40, 0, 8'h00);
        br(OP_BRANCH_IF_PLUS, 8'h04, 1, 8'h00);
        cmp(OP_CMP_DIRECT, 16'h0003, 16'h0005, 16'h0002);
        br(OP_BRANCH_IF_MINUS, 8'hF0, 1, 8'h00);
        br(OP_BRANCH_IF_PLUS, 8'h30, 0, 8'h00);
        br(OP_BRANCH_CARRY_SET, 8'h30, 0, 8'h00);
        br(OP_BRANCH_NOT_EQUAL, 8'h06, 1, 8'h00);
        br(OP_BRANCH_IF_EQUAL, 8'h06, 0, 8'h00);
        br(OP_BRANCH_OVF_CLEAR, 8'h02, 1, 8'h00);
        br(OP_BRANCH_OVF_SET, 8'h02, 0, 8'h00);
        ex(OP_STATUS_BITS_CLEAR, 8'h80, 16'h0000, 16'h0000, 16'h0000);
        m_status = m_status & 16'hFF7F;
        m_pc = m_pc + 16'h0002;
        chk(0);
        cmp(OP_CMP_IMMEDIATE, 16'h0005, 16'h0003, 16'h0003);
        // Carry stands set here, so these two clears must leave it alone
        ex(OP_OVERFLOW_CLEAR, 8'h00, 16'h0000, 16'h0000, 16'h0000);
        ex(OP_WIDTH_FLAG_CLEAR, 8'h00, 16'h0000, 16'h0000, 16'h0000);
        m_pc = m_pc + 16'h0002;
        chk(0);
        ex(OP_CARRY_CLEAR, 8'h00, 16'h0000, 16'h0000, 16'h0000);
        m_status[FLAG_C] = 0;
        m_pc = m_pc + 16'h0001;
        chk(0);
        ex(OP_MEMORY_BIT_CLEAR, 8'h0F, 16'h1234, 16'h0000, 16'h00A5);
        m_pc = m_pc + 16'h0003;
        chk(1);
        cmp16(o_mem_addr, 16'h1234, "clear address");
        cmp16({8'h00, o_mem_wdata}, 16'h00A0, "clear data");
        cmp(OP_CMP_IMMEDIATE, 16'h0005, 16'h0003, 16'h0003);
        // Soft interrupt; a carry clear offered while busy must be ignored
        ex(OP_SOFTWARE_INTERRUPT, 8'h00, 16'h0000, 16'h0000, 16'h0000);
        m_pc = m_pc + 16'h0002;
        pushes = '{m_bank, m_pc[15:8], m_pc[7:0], m_status[15:8], m_status[7:0]};
        for (int k = 0; k < 5; k++) begin
            cmp16({15'h0000, o_mem_we}, 16'h0001, "push strobe");
            cmp16(o_mem_addr, m_sp - k[15:0], "push address");
            cmp16({8'h00, o_mem_wdata}, {8'h00, pushes[k]}, "push data");
            cmp16({15'h0000, o_busy}, {15'h0000, (k < 4)}, "push busy");
            i_opcode = OP_CARRY_CLEAR;
            i_valid = (k == 1);
            @(posedge i_clk);
            #1;
        end
        @(posedge i_clk);
        #1;
        m_sp = m_sp - 16'h0005;
        m_status[FLAG_I] = 1;
        m_pc = TRAP_VECTOR;
        m_bank = BANK_RESET;
        chk(0);
        br(OP_BRANCH_ALWAYS, 8'h10, 1, 8'h01);
        br(OP_BRANCH_ALWAYS, 8'hF0, 1, 8'hFF);
        test_done;
    end
    // Watchdog well beyond the roughly sixty cycles the sequence needs
    initial begin
        #100000;
        n_fail++;
        test_done;
    end
endmodule // testbench
